// ==== include/phyled_pkg.sv ====
/*
  Shared constants and types of the PHY mode strap and indicator block.
  Assumes a single system clock; no module of its own.
*/
`default_nettype none
package phyled_pkg;
  // Clock and stretch timing
  localparam int CLK_MHZ = 40;
  localparam int STRETCH_US = 50000;
  localparam int STRETCH_CYC = STRETCH_US * CLK_MHZ;
  // Register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h4;
  localparam logic [3:0] OFS_ISTAT = 4'h8;
  localparam logic [3:0] OFS_IMASK = 4'hC;
  // Control fields and reset value
  localparam int CTRL_IND_EN = 0;
  localparam int CTRL_SOFT_RST = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;
  // Interrupt event bits
  localparam int IRQ_W = 3;
  localparam int EV_LINK = 0;
  localparam int EV_COL = 1;
  localparam int EV_RSVD = 2;
  // AXI responses
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // Mode strap encodings
  localparam logic [2:0] MODE_AN_ALL = 3'h0;
  localparam logic [2:0] MODE_AN_100 = 3'h1;
  localparam logic [2:0] MODE_AN_10 = 3'h2;
  localparam logic [2:0] MODE_RSVD = 3'h3;
  localparam logic [2:0] MODE_F100_FD = 3'h4;
  localparam logic [2:0] MODE_F100_HD = 3'h5;
  localparam logic [2:0] MODE_F10_FD = 3'h6;
  localparam logic [2:0] MODE_F10_HD = 3'h7;
  // Advertised abilities: {100FD,100HD,10FD,10HD}
  localparam logic [3:0] ADV_ALL = 4'hF;
  localparam logic [3:0] ADV_100 = 4'hC;
  localparam logic [3:0] ADV_10 = 4'h3;
  localparam logic [3:0] ADV_NONE = 4'h0;
  // Decoded operating mode
  typedef struct packed {
    logic anEnable;
    logic [3:0] advertise;
    logic force100;
    logic forceFullDuplex;
    logic reserved;
  } phyled_mode_t;
  // Live link state from the PHY core
  typedef struct packed {
    logic linkUp;
    logic speed100;
    logic fullDuplex;
  } phyled_link_t;
endpackage
`default_nettype wire

// ==== verilog/phyled_top.sv ====
/*
  PHY mode strap decode and status indicators with AXI4-Lite registers.
  Assumes: clk_sys stands in for the 40 MHz PHY reference; all inputs
  are synchronous to it; strap pins carry board pull-downs.
*/
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
// Contract
// - PHY core reset while power-on reset low
// - Strap 0: negotiate, advertise everything
// - 1: 100 only; 2: 10 only; 3 reserved
// - Straps 4,5 force 100 full/half
// - Straps 6,7 force 10 full/half
// - Undriven strap reads zero, full negotiation
// - Receive indicator low while receiving
// - Indicators toggle under sustained traffic
// - Link indicator high while link present
// - Link indicator toggles on traffic
// - Speed indicator high at 100 Mbps
// - Duplex indicator high at full duplex
// - Logic runs from the PHY reference clock
`timescale 1ns/1ps
`default_nettype none
module phyled_top #(
  parameter int STRETCH_CYC = phyled_pkg::STRETCH_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic phy_por_reset_n,
  // Strap and PHY core status
  input wire logic [2:0] modeStrap,
  input wire logic txActive,
  input wire logic rxActive,
  input wire logic collision,
  input wire phyled_pkg::phyled_link_t linkIn,
  // PHY core control
  output logic phyCoreReset,
  output phyled_pkg::phyled_mode_t modeOut,
  // Indicators
  output logic tx_activity_ind_n,
  output logic rx_activity_ind_n,
  output logic link_up_ind,
  output logic speed_100_ind,
  output logic collision_ind_n,
  output logic full_duplex_ind,
  output logic irq,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // Counter sizing: on phase then off phase
  localparam int CNT_W = $clog2(2 * STRETCH_CYC + 1);
  localparam logic [CNT_W-1:0] HALF = CNT_W'(STRETCH_CYC);
  localparam logic [CNT_W-1:0] FULL = CNT_W'(2 * STRETCH_CYC);
  localparam logic [CNT_W-1:0] ZERO = '0;
  localparam int NCH = 4; // tx, rx, collision, link traffic

  //////////////////////////////////////////////////////////////////
  // Reset of the PHY core
  //////////////////////////////////////////////////////////////////
  logic [1:0] ctrl_q; // Indicator enable, soft reset
  wire phyRstD = !phy_por_reset_n || ctrl_q[phyled_pkg::CTRL_SOFT_RST];
  // Core reset follows the pin or the soft reset bit one cycle later
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      phyCoreReset <= 1'b1;
    end else begin
      phyCoreReset <= phyRstD;
    end
  end

  //////////////////////////////////////////////////////////////////
  // Strap capture and mode decode
  //////////////////////////////////////////////////////////////////
  phyled_pkg::phyled_mode_t modeD;
  logic [2:0] mode_q;
  // Decode table for the three strap bits
  always_comb begin
    modeD = '0;
    modeD.advertise = phyled_pkg::ADV_NONE;
    case (modeStrap)
      phyled_pkg::MODE_AN_ALL: begin
        modeD.anEnable = 1'b1;
        modeD.advertise = phyled_pkg::ADV_ALL;
      end
      phyled_pkg::MODE_AN_100: begin
        modeD.anEnable = 1'b1;
        modeD.advertise = phyled_pkg::ADV_100;
      end
      phyled_pkg::MODE_AN_10: begin
        modeD.anEnable = 1'b1;
        modeD.advertise = phyled_pkg::ADV_10;
      end
      phyled_pkg::MODE_RSVD: begin
        // Reserved: fall back to full negotiation, flag it
        modeD.anEnable = 1'b1;
        modeD.advertise = phyled_pkg::ADV_ALL;
        modeD.reserved = 1'b1;
      end
      phyled_pkg::MODE_F100_FD: begin
        modeD.force100 = 1'b1;
        modeD.forceFullDuplex = 1'b1;
      end
      phyled_pkg::MODE_F100_HD: begin
        modeD.force100 = 1'b1;
      end
      phyled_pkg::MODE_F10_FD: begin
        modeD.forceFullDuplex = 1'b1;
      end
      phyled_pkg::MODE_F10_HD: begin
        modeD.forceFullDuplex = 1'b0;
      end
      default: begin
        modeD.anEnable = 1'b1;
      end
    endcase
  end
  // Strap is followed while the core is in reset, frozen after.
  // Reset value zero equals the pulled-down, undriven strap.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode_q <= phyled_pkg::MODE_AN_ALL;
      modeOut <= '0;
      modeOut.anEnable <= 1'b1;
      modeOut.advertise <= phyled_pkg::ADV_ALL;
    end else if (phyCoreReset) begin
      mode_q <= modeStrap;
      modeOut <= modeD;
    end
  end

  //////////////////////////////////////////////////////////////////
  // Activity stretch: on phase, then forced off phase
  //////////////////////////////////////////////////////////////////
  wire indEn = ctrl_q[phyled_pkg::CTRL_IND_EN] && !phyCoreReset;
  wire [NCH-1:0] chEvent = {txActive || rxActive, collision, rxActive, txActive};
  logic [NCH-1:0] chOn;
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : gStretch
      logic [CNT_W-1:0] cnt_q;
      // Counter on the reference clock sets the visible time
      always_ff @(posedge clk_sys) begin
        if (reset || !indEn) begin
          cnt_q <= ZERO;
        end else if (cnt_q != ZERO) begin
          cnt_q <= cnt_q - 1'b1;
        end else if (chEvent[gi]) begin
          cnt_q <= FULL;
        end
      end
      // Off phase keeps steady traffic visibly blinking
      assign chOn[gi] = cnt_q > HALF;
    end
  endgenerate

  //////////////////////////////////////////////////////////////////
  // Indicator outputs
  //////////////////////////////////////////////////////////////////
  wire linkOk = indEn && linkIn.linkUp;
  wire spdD = modeOut.anEnable ? linkIn.speed100 : modeOut.force100;
  wire fdxD = modeOut.anEnable ? linkIn.fullDuplex : modeOut.forceFullDuplex;
  // All indicators registered; off while disabled or in reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tx_activity_ind_n <= 1'b1;
      rx_activity_ind_n <= 1'b1;
      collision_ind_n <= 1'b1;
      link_up_ind <= 1'b0;
      speed_100_ind <= 1'b0;
      full_duplex_ind <= 1'b0;
    end else begin
      tx_activity_ind_n <= !chOn[0];
      rx_activity_ind_n <= !chOn[1];
      collision_ind_n <= !chOn[2];
      link_up_ind <= linkOk && !chOn[3];
      speed_100_ind <= linkOk && spdD;
      full_duplex_ind <= linkOk && fdxD;
    end
  end

  //////////////////////////////////////////////////////////////////
  // Interrupt status and mask
  //////////////////////////////////////////////////////////////////
  logic [phyled_pkg::IRQ_W-1:0] istat_q;
  logic [phyled_pkg::IRQ_W-1:0] imask_q;
  logic linkSeen_q;
  logic rsvdSeen_q;
  wire [phyled_pkg::IRQ_W-1:0] evSet = {
    modeOut.reserved && !rsvdSeen_q,
    collision && linkOk,
    linkOk != linkSeen_q};
  wire wrTake;
  wire [3:0] wrAddr;
  wire [phyled_pkg::IRQ_W-1:0] w1c = (wrTake && wrAddr == phyled_pkg::OFS_ISTAT)
    ? s_axi_wdata[phyled_pkg::IRQ_W-1:0] : '0;
  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      istat_q <= '0;
      linkSeen_q <= 1'b0;
      rsvdSeen_q <= 1'b0;
      irq <= 1'b0;
    end else begin
      istat_q <= (istat_q & ~w1c) | evSet;
      linkSeen_q <= linkOk;
      rsvdSeen_q <= modeOut.reserved;
      irq <= |(((istat_q & ~w1c) | evSet) & imask_q);
    end
  end

  //////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  //////////////////////////////////////////////////////////////////
  wire wrFire = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  assign wrAddr = {s_axi_awaddr[3:2], 2'h0};
  wire wrMapped = (wrAddr == phyled_pkg::OFS_CTRL || wrAddr == phyled_pkg::OFS_STAT
    || wrAddr == phyled_pkg::OFS_ISTAT || wrAddr == phyled_pkg::OFS_IMASK) && s_axi_awaddr[1:0] == 2'h0;
  wire wrHs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign wrTake = wrHs && wrMapped && s_axi_wstrb[0];
  // Ready after both are offered; response only after the handshake
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= phyled_pkg::RESP_OK;
      ctrl_q <= phyled_pkg::CTRL_RST;
      imask_q <= '0;
    end else begin
      s_axi_awready <= wrFire;
      s_axi_wready <= wrFire;
      if (wrHs) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? phyled_pkg::RESP_OK : phyled_pkg::RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wrTake && wrAddr == phyled_pkg::OFS_CTRL) begin
        ctrl_q <= s_axi_wdata[1:0];
      end
      if (wrTake && wrAddr == phyled_pkg::OFS_IMASK) begin
        imask_q <= s_axi_wdata[phyled_pkg::IRQ_W-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  //////////////////////////////////////////////////////////////////
  wire rdFire = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  wire rdHs = s_axi_arvalid && s_axi_arready;
  wire [3:0] rdAddr = {s_axi_araddr[3:2], 2'h0};
  // Status word: live link state, strap, reserved flag
  wire [31:0] statWord = {24'h0, phyCoreReset, modeOut.reserved, mode_q,
    linkOk && fdxD, linkOk && spdD, linkOk};
  wire [31:0] rdWord = (rdAddr == phyled_pkg::OFS_CTRL) ? {30'h0, ctrl_q}
    : (rdAddr == phyled_pkg::OFS_STAT) ? statWord
    : (rdAddr == phyled_pkg::OFS_ISTAT) ? {29'h0, istat_q}
    : (rdAddr == phyled_pkg::OFS_IMASK) ? {29'h0, imask_q} : 32'h0;
  wire rdMapped = (rdAddr == phyled_pkg::OFS_CTRL || rdAddr == phyled_pkg::OFS_STAT
    || rdAddr == phyled_pkg::OFS_ISTAT || rdAddr == phyled_pkg::OFS_IMASK) && s_axi_araddr[1:0] == 2'h0;
  // Data launched after the address handshake, held until rready
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= phyled_pkg::RESP_OK;
    end else begin
      s_axi_arready <= rdFire;
      if (rdHs) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMapped ? rdWord : 32'h0;
        s_axi_rresp <= rdMapped ? phyled_pkg::RESP_OK : phyled_pkg::RESP_ERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////
  // Checks
  //////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_por_holds_core: assert property (
    !phy_por_reset_n |=> phyCoreReset
  ) else $error("core not in reset while por low");
  a_mode_all_adv: assert property (
    mode_q == phyled_pkg::MODE_AN_ALL |-> modeOut.anEnable && modeOut.advertise == 4'hF
  ) else $error("mode 0 decode wrong");
  a_mode_an_sub: assert property (
    mode_q == phyled_pkg::MODE_AN_10 |-> modeOut.anEnable && modeOut.advertise == 4'h3
  ) else $error("mode 2 decode wrong");
  a_force_100_fd: assert property (
    mode_q == phyled_pkg::MODE_F100_FD |-> !modeOut.anEnable && modeOut.force100 && modeOut.forceFullDuplex
  ) else $error("mode 4 decode wrong");
  a_force_10_hd: assert property (
    mode_q == phyled_pkg::MODE_F10_HD |-> !modeOut.anEnable && !modeOut.force100 && !modeOut.forceFullDuplex
  ) else $error("mode 7 decode wrong");
  a_tx_led_on: assert property (
    txActive && gStretch[0].cnt_q == ZERO && indEn ##1 indEn |-> ##1 !tx_activity_ind_n
  ) else $error("tx indicator missed");
  a_rx_led_on: assert property (
    rxActive && gStretch[1].cnt_q == ZERO && indEn ##1 indEn |-> ##1 !rx_activity_ind_n
  ) else $error("rx indicator missed");
  a_col_led_on: assert property (
    collision && gStretch[2].cnt_q == ZERO && indEn ##1 indEn |-> ##1 !collision_ind_n
  ) else $error("collision indicator missed");
  a_link_low: assert property (
    !linkIn.linkUp |=> !link_up_ind && !speed_100_ind && !full_duplex_ind
  ) else $error("link indicators high without link");
  a_speed_an: assert property (
    linkOk && modeOut.anEnable |=> speed_100_ind == $past(linkIn.speed100)
  ) else $error("speed indicator wrong");
  a_duplex_an: assert property (
    linkOk && modeOut.anEnable |=> full_duplex_ind == $past(linkIn.fullDuplex)
  ) else $error("duplex indicator wrong");
endmodule // phyled_top
`default_nettype wire

// ==== test/phyled_board.sv ====
/*
  Board model: strap resistors on the mode pins.
  Assumes the bench sets the strap only while power-on reset is held low.
*/
`timescale 1ns/1ps
`default_nettype none
module phyled_board (
  // Strap setting from the bench
  input wire logic [2:0] strapVal,
  input wire logic strapDriven,
  // Strap pins toward the block
  output logic [2:0] modeStrap
);
  ////////////////////////////////////////////////////////////////
  // Open pins fall to the pull-down, so no level is left unknown
  assign modeStrap = strapDriven ? strapVal : 3'h0;
endmodule // phyled_board
`default_nettype wire

// ==== test/tb_top.sv ====
/*
  Self-checking bench for the mode strap and indicator block.
  Assumes a short stretch parameter and registers at the note's offsets.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int S = 4; // Short stretch keeps the run brief
  logic clk_sys = 1'b0, reset = 1'b1, porN = 1'b0, strapDriven = 1'b0;
  logic [2:0] strapVal = 3'h0, evt = 3'h0;
  logic [2:0] modeStrap;
  phyled_pkg::phyled_link_t linkIn = '0;
  phyled_pkg::phyled_mode_t modeOut;
  logic phyCoreReset, txN, rxN, colN, linkInd, spdInd, fdxInd, irq;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int n_fail = 0, tests_run = 0;
  wire logic [2:0] actN = {colN, rxN, txN};
  phyled_board i_board (.strapVal(strapVal), .strapDriven(strapDriven), .modeStrap(modeStrap));
  phyled_top #(.STRETCH_CYC(S)) i_dut (.clk_sys(clk_sys), .reset(reset), .phy_por_reset_n(porN),
    .modeStrap(modeStrap), .txActive(evt[0]), .rxActive(evt[1]), .collision(evt[2]), .linkIn(linkIn),
    .phyCoreReset(phyCoreReset), .modeOut(modeOut), .tx_activity_ind_n(txN), .rx_activity_ind_n(rxN),
    .link_up_ind(linkInd), .speed_100_ind(spdInd), .collision_ind_n(colN), .full_duplex_ind(fdxInd),
    .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  ////////////////////////////////////////////////////////////////
  // Clock generator
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Closing report, the single end of the run
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask
  // A spent bound counts as a mismatch and ends the run
  task automatic tmo(input int k, input int lim);
    if (k >= lim) begin
      n_fail++;
      print_verdict();
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  ////////////////////////////////////////////////////////////////
  // AXI4-Lite master cycles
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int k = 0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      k++;
    end while (bvalid !== 1'b1 && k < 20);
    tmo(k, 20);
    chk(bresp, er);
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [1:0] er);
    int k = 0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arready === 1'b1) arvalid <= 1'b0;
      k++;
    end while (rvalid !== 1'b1 && k < 20);
    tmo(k, 20);
    rd = rdata;
    chk(rresp, er);
    rready <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  // Strap capture under power-on reset, then decode check
  task automatic t_mode(input logic [2:0] m, input logic drv);
    @(posedge clk_sys);
    porN <= 1'b0;
    strapVal <= m;
    strapDriven <= drv;
    idle(3);
    chk(phyCoreReset, 1'b1);
    @(posedge clk_sys);
    porN <= 1'b1;
    idle(3);
    chk(phyCoreReset, 1'b0);
    if (!drv) m = 3'h0;
    chk({modeOut.anEnable, modeOut.reserved}, {m < 4, m == 3});
    if (m < 4) chk(modeOut.advertise, m == 1 ? 4'hC : m == 2 ? 4'h3 : 4'hF);
    else chk({modeOut.force100, modeOut.forceFullDuplex}, {m < 6, !m[0]});
    axi_rd(4'h4, 2'h0);
    chk(rd[5:3], m);
  endtask
  // One short event must light its indicator for exactly the stretch
  task automatic t_stretch(input int w);
    int k = 0;
    int n = 0;
    logic blink = 1'b0;
    @(posedge clk_sys);
    evt <= 3'h1 << w;
    @(posedge clk_sys);
    evt <= 3'h0;
    while (actN[w] !== 1'b0 && k < 8) begin
      @(negedge clk_sys);
      k++;
    end
    tmo(k, 8);
    while (actN[w] === 1'b0 && n < 20) begin
      if (linkInd === 1'b0) blink = 1'b1;
      @(negedge clk_sys);
      n++;
    end
    chk(n, S);
    if (w == 0) chk(blink, 1'b1);
    idle(2 * S + 2);
  endtask
  // Link, speed and duplex follow the negotiated or forced state
  task automatic t_link(input logic [2:0] li, input logic [2:0] exp);
    @(posedge clk_sys);
    linkIn <= li;
    idle(3);
    chk({linkInd, spdInd, fdxInd}, exp);
  endtask
  // Link-change event raises the interrupt only while unmasked
  task automatic t_irq();
    axi_rd(4'h8, 2'h0);
    chk(rd[2:0], 3'h7);
    axi_wr(4'hC, 32'h1, 2'h0);
    axi_wr(4'h8, 32'h7, 2'h0);
    t_link(3'h0, 3'h0);
    chk(irq, 1'b1);
    axi_rd(4'h8, 2'h0);
    chk(rd[0], 1'b1);
    axi_wr(4'h8, 32'h1, 2'h0);
    idle(2);
    chk(irq, 1'b0);
    axi_wr(4'hC, 32'h0, 2'h0);
    t_link(3'h7, 3'h7);
    chk(irq, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    idle(2);
    chk({txN, rxN, colN}, 3'h7);
    axi_wr(4'h2, 32'h0, 2'h2);
    axi_rd(4'h2, 2'h2);
    chk(rd, 32'h0);
    axi_rd(4'h0, 2'h0);
    chk(rd[1:0], 2'h1);
    axi_rd(4'hC, 2'h0);
    chk(rd, 32'h0);
    for (int m = 0; m < 8; m++) t_mode(m[2:0], 1'b1);
    t_mode(3'h5, 1'b0);
    t_link(3'h7, 3'h7);
    t_link(3'h4, 3'h4);
    t_link(3'h3, 3'h0);
    t_link(3'h7, 3'h7);
    for (int w = 0; w < 3; w++) t_stretch(w);
    t_irq();
    t_mode(3'h7, 1'b1);
    t_link(3'h7, 3'h4);
    axi_wr(4'h0, 32'h3, 2'h0);
    idle(2);
    chk(phyCoreReset, 1'b1);
    axi_wr(4'h0, 32'h1, 2'h0);
    idle(2);
    chk(phyCoreReset, 1'b0);
    print_verdict();
  end
  // Watchdog against a hang
  initial begin
    #2000000;
    n_fail++;
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
